// File: hdl/temp_lut_pkg.sv
// constants, register map and state codes of the temperature table datapath
// What this block does
// - two tables, one per channel word
// - copy nonvolatile image before any output
// - code is 12-bit twos complement, 1/16 C
// - result refreshed each conversion, every 25 ms
// - result zero at start, first after 25 ms
// - upper holds bits 3:0, lower bits 7:0
// - highest stored temperature is 127.9375 C
// - table input from sensor or forced code
// - code bits 11:6 address the table
// - each location holds unsigned 4-bit increment
// - reference fixed at 24 C, offset there
// - above reference, add summed increments to offset
// - below reference, subtract summed increments
// - interpolate with low six bits over 64
// - 12-bit result goes to channel converter
// - invert bit swaps add and subtract
// - below: offset minus sum plus fraction, signed
// - one register per location, -28 C first
package temp_lut_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CODE_UPPER = 12'h000;
    localparam logic [11:0] OFS_CODE_LOWER = 12'h004;
    localparam logic [11:0] OFS_FORCE_UPPER = 12'h008;
    localparam logic [11:0] OFS_FORCE_LOWER = 12'h00C;
    localparam logic [11:0] OFS_MODE = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [11:0] OFS_OFFSET0_HIGH = 12'h018;
    localparam logic [11:0] OFS_OFFSET0_LOW = 12'h01C;
    localparam logic [11:0] OFS_OFFSET1_HIGH = 12'h020;
    localparam logic [11:0] OFS_OFFSET1_LOW = 12'h024;
    localparam logic [11:0] OFS_WORD0 = 12'h028;
    localparam logic [11:0] OFS_WORD1 = 12'h02C;
    localparam logic [3:0] TABLE0_PAGE = 4'h1;
    localparam logic [3:0] TABLE1_PAGE = 4'h2;
    // field positions
    localparam int POL_BIT = 7;
    localparam int FORCE_BIT = 0;
    localparam int BOOT_BIT = 0;
    // reset values
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [11:0] FORCE_RESET = 12'h000;
    localparam logic [11:0] WORD_RESET = 12'h000;
    localparam logic [11:0] WORD_MAX = 12'hFFF;
    // table geometry: 24 C is location 6, -28 C is location -7
    localparam logic [6:0] REF_LOCATION = 7'h06;
    localparam logic [5:0] FLOOR_LOCATION = 6'h39;
    localparam logic [6:0] FLOOR_STEP = 7'h73;
    localparam logic [6:0] BELOW_BIAS = 7'h0D;
    localparam logic [6:0] ABOVE_BIAS = 7'h0C;
    // conversion timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CONV_TIME_MS = 25;
    localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sequencer states
    typedef enum logic [4:0] {
        S_BOOT = 5'h01,
        S_LOAD = 5'h02,
        S_STEP = 5'h04,
        S_FRAC = 5'h08,
        S_OUT = 5'h10
    } calc_state_t;
endpackage

// File: hdl/temp_lut_interpolator.sv
// two-channel temperature table interpolator with an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module temp_lut_interpolator
    import temp_lut_pkg::*;
#(
    parameter int CONV_PERIOD = CONV_CYCLES,
    parameter logic [255:0] NV_TABLE0 = '0,
    parameter logic [255:0] NV_TABLE1 = '0,
    parameter logic [11:0] NV_OFFSET0 = 12'h800,
    parameter logic [11:0] NV_OFFSET1 = 12'h800,
    parameter logic NV_INVERT0 = 1'b0,
    parameter logic NV_INVERT1 = 1'b0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] sensorCode,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [11:0] convWord0,
    output logic [11:0] convWord1,
    output logic wordValid
);
    // map check shared by read and write sides
    function automatic logic isMapped(input logic [11:0] a);
        return (a[1:0] == 2'h0) && ((a <= OFS_WORD1) ||
            (a[11:8] == TABLE0_PAGE) || (a[11:8] == TABLE1_PAGE));
    endfunction

    // table position of increment j: -13..-1 -> 0..12, 1.. -> 13..
    function automatic logic [5:0] incAddr(input logic [6:0] j);
        logic [6:0] s;
        s = j[6] ? (j + BELOW_BIAS) : (j + ABOVE_BIAS);
        return s[5:0];
    endfunction

    // offset plus or minus integer part of the sum, saturated
    function automatic logic [11:0] outWord(input logic [11:0] reference_offset_value,
                                            input logic [15:0] acc,
                                            input logic add);
        logic signed [15:0] v;
        v = add ? $signed({4'h0, reference_offset_value}) + $signed({6'h0, acc[15:6]})
                : $signed({4'h0, reference_offset_value}) - $signed({6'h0, acc[15:6]});
        if (v < 0) return WORD_RESET;
        if (v > $signed({4'h0, WORD_MAX})) return WORD_MAX;
        return v[11:0];
    endfunction

    logic [3:0] inc0 [0:63]; // channel 0 increments, 4 bits each
    logic [3:0] inc1 [0:63]; // channel 1 increments
    logic [11:0] sensorMeta; // first stage, read only by next stage
    logic [11:0] sensorSync; // second stage
    logic [31:0] convCount; // conversion period timer
    logic [11:0] thermalCode; // latest conversion result
    logic [11:0] forcedCode; // software-supplied code
    logic forceEn; // table input from forced code
    logic [11:0] offset0; // channel 0 output at 24 C
    logic [11:0] offset1;
    logic invert0; // channel 0 slope reversal
    logic invert1;
    calc_state_t state;
    logic [5:0] bootIdx; // copy pointer into the image
    logic [5:0] stepIdx; // current interval being summed
    logic [5:0] steps; // intervals between reference and target
    logic above; // target at or above reference
    logic [5:0] interp_fraction_bits; // interpolation fraction bits
    logic [15:0] acc0; // sum in 1/64 units
    logic [15:0] acc1;
    logic awHeld; // write address taken, waiting for data
    logic [11:0] awAddrHeld;
    logic wHeld; // write data taken, waiting for address
    logic [31:0] wdataHeld;
    logic [3:0] wstrbHeld;

    // ---- table input selection and location arithmetic ----
    wire logic convTick = (convCount == 32'(CONV_PERIOD - 1));
    wire logic [11:0] tempIn = forceEn ? forcedCode : thermalCode;
    wire logic [5:0] location = tempIn[11:6];
    wire logic belowFloor = $signed(location) < $signed(FLOOR_LOCATION);
    // distance from the 24 C reference; below -28 C no table exists
    wire logic [6:0] kVal = belowFloor ? FLOOR_STEP
                          : ({location[5], location} - REF_LOCATION);
    wire logic [6:0] kNeg = 7'h00 - kVal;
    wire logic aboveNow = !kVal[6];
    wire logic [5:0] stepsNow = aboveNow ? kVal[5:0] : kNeg[5:0];
    wire logic [6:0] fracJ = above ? ({1'b0, steps} + 7'h01)
                                   : (7'h00 - {1'b0, steps});
    wire logic [6:0] stepJ = above ? {1'b0, stepIdx}
                                   : (7'h00 - {1'b0, stepIdx});
    wire logic [6:0] curJ = (state == S_FRAC) ? fracJ : stepJ;
    wire logic [5:0] curAddr = incAddr(curJ);
    wire logic [3:0] delta0 = inc0[curAddr];
    wire logic [3:0] delta1 = inc1[curAddr];
    // operands widened first so the product keeps all ten bits
    wire logic [9:0] part0 = {4'h0, interp_fraction_bits} * {6'h0, delta0};
    wire logic [9:0] part1 = {4'h0, interp_fraction_bits} * {6'h0, delta1};

    // ---- bus write side ----
    assign awready = !awHeld && !bvalid;
    assign wready = !wHeld && !bvalid;
    wire logic doWrite = awHeld && wHeld && !bvalid;
    wire logic lane0 = wstrbHeld[0];
    wire logic bootBusy = (state == S_BOOT);
    wire logic wrTab0 = (awAddrHeld[11:8] == TABLE0_PAGE);
    wire logic wrTab1 = (awAddrHeld[11:8] == TABLE1_PAGE);
    wire logic [5:0] wrIdx = awAddrHeld[7:2];

    // ---- bus read mux ----
    wire logic [5:0] rdIdx = araddr[7:2];
    wire logic [31:0] rdWord =
        (araddr == OFS_CODE_UPPER) ? {28'h0, thermalCode[11:8]} :
        (araddr == OFS_CODE_LOWER) ? {24'h0, thermalCode[7:0]} :
        (araddr == OFS_FORCE_UPPER) ? {28'h0, forcedCode[11:8]} :
        (araddr == OFS_FORCE_LOWER) ? {24'h0, forcedCode[7:0]} :
        (araddr == OFS_MODE) ? {31'h0, forceEn} :
        (araddr == OFS_STATUS) ? {31'h0, !bootBusy} :
        (araddr == OFS_OFFSET0_HIGH) ? {24'h0, invert0, 3'h0,
                                        offset0[11:8]} :
        (araddr == OFS_OFFSET0_LOW) ? {24'h0, offset0[7:0]} :
        (araddr == OFS_OFFSET1_HIGH) ? {24'h0, invert1, 3'h0,
                                        offset1[11:8]} :
        (araddr == OFS_OFFSET1_LOW) ? {24'h0, offset1[7:0]} :
        (araddr == OFS_WORD0) ? {20'h0, convWord0} :
        (araddr == OFS_WORD1) ? {20'h0, convWord1} :
        (araddr[11:8] == TABLE0_PAGE) ? {28'h0, inc0[rdIdx]} :
        (araddr[11:8] == TABLE1_PAGE) ? {28'h0, inc1[rdIdx]} : 32'h0;
    assign arready = !rvalid;

    // sensor pins are asynchronous: two stages before use
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sensorMeta <= CODE_RESET;
            sensorSync <= CODE_RESET;
        end else begin
            sensorMeta <= sensorCode;
            sensorSync <= sensorMeta;
        end
    end

    // conversion timer; result zero until the first period ends
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            convCount <= 32'h0;
            thermalCode <= CODE_RESET;
        end else if (convTick) begin
            convCount <= 32'h0;
            // twos complement 12 bits cannot pass 127.9375 C
            thermalCode <= sensorSync;
        end else begin
            convCount <= convCount + 32'h1;
        end
    end

    // table memory: image copy at start, then software writes
    always_ff @(posedge mclk) begin
        if (bootBusy) begin
            inc0[bootIdx] <= NV_TABLE0[{bootIdx, 2'h0} +: 4];
            inc1[bootIdx] <= NV_TABLE1[{bootIdx, 2'h0} +: 4];
        end else if (doWrite && lane0 && wrTab0) begin
            inc0[wrIdx] <= wdataHeld[3:0];
        end else if (doWrite && lane0 && wrTab1) begin
            inc1[wrIdx] <= wdataHeld[3:0];
        end
    end

    // configuration registers; image copy beats software writes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            forcedCode <= FORCE_RESET;
            forceEn <= 1'b0;
            offset0 <= WORD_RESET;
            offset1 <= WORD_RESET;
            invert0 <= 1'b0;
            invert1 <= 1'b0;
        end else if (bootBusy) begin
            offset0 <= NV_OFFSET0;
            offset1 <= NV_OFFSET1;
            invert0 <= NV_INVERT0;
            invert1 <= NV_INVERT1;
        end else if (doWrite && lane0) begin
            case (awAddrHeld)
                OFS_FORCE_UPPER: forcedCode[11:8] <= wdataHeld[3:0];
                OFS_FORCE_LOWER: forcedCode[7:0] <= wdataHeld[7:0];
                OFS_MODE: forceEn <= wdataHeld[FORCE_BIT];
                OFS_OFFSET0_HIGH: begin
                    offset0[11:8] <= wdataHeld[3:0];
                    invert0 <= wdataHeld[POL_BIT];
                end
                OFS_OFFSET0_LOW: offset0[7:0] <= wdataHeld[7:0];
                OFS_OFFSET1_HIGH: begin
                    offset1[11:8] <= wdataHeld[3:0];
                    invert1 <= wdataHeld[POL_BIT];
                end
                OFS_OFFSET1_LOW: offset1[7:0] <= wdataHeld[7:0];
                default: ; // read-only or table: nothing here
            endcase
        end
    end

    // write channel capture: address and data in either order
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrHeld <= 12'h000;
            wdataHeld <= 32'h0;
            wstrbHeld <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awAddrHeld <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wdataHeld <= wdata;
                wstrbHeld <= wstrb;
            end
            if (doWrite) begin
                // both parts present: commit and answer
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= isMapped(awAddrHeld) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel: registered answer one edge after the address
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdWord;
            rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // sequencer: boot copy, then endless walk from the reference;
    // one interval per cycle trades speed for one adder per channel
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= S_BOOT;
            bootIdx <= 6'h00;
            stepIdx <= 6'h00;
            steps <= 6'h00;
            above <= 1'b1;
            interp_fraction_bits <= 6'h00;
            acc0 <= 16'h0;
            acc1 <= 16'h0;
            convWord0 <= WORD_RESET;
            convWord1 <= WORD_RESET;
            wordValid <= 1'b0;
        end else begin
            case (state)
                S_BOOT: begin
                    // no output before the whole image is in place
                    bootIdx <= bootIdx + 6'h01;
                    if (bootIdx == 6'h3F) begin
                        state <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    // freeze the input code for this pass
                    above <= aboveNow;
                    steps <= stepsNow;
                    interp_fraction_bits <= belowFloor ? 6'h00 : tempIn[5:0];
                    stepIdx <= 6'h01;
                    acc0 <= 16'h0;
                    acc1 <= 16'h0;
                    state <= (stepsNow == 6'h00) ? S_FRAC : S_STEP;
                end
                S_STEP: begin
                    // whole increments between reference and target
                    acc0 <= acc0 + {6'h0, delta0, 6'h00};
                    acc1 <= acc1 + {6'h0, delta1, 6'h00};
                    if (stepIdx == steps) begin
                        state <= S_FRAC;
                    end else begin
                        stepIdx <= stepIdx + 6'h01;
                    end
                end
                S_FRAC: begin
                    if (above) begin
                        // part of the next interval above
                        acc0 <= acc0 + {6'h0, part0};
                        acc1 <= acc1 + {6'h0, part1};
                    end else begin
                        // sum never smaller than the part removed
                        acc0 <= acc0 - {6'h0, part0};
                        acc1 <= acc1 - {6'h0, part1};
                    end
                    state <= S_OUT;
                end
                S_OUT: begin
                    // fraction truncated, sign set by side and slope
                    convWord0 <= outWord(offset0, acc0,
                                         above ^ invert0);
                    convWord1 <= outWord(offset1, acc1,
                                         above ^ invert1);
                    wordValid <= 1'b1;
                    state <= S_LOAD;
                end
                default: state <= S_BOOT;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: testbench/temp_lut_checker_assertions.sv
// port-level assertions for the temperature table interpolator
`timescale 1ns/1ps
`default_nettype none
module temp_lut_checker
    import temp_lut_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [11:0] convWord0,
    input wire logic [11:0] convWord1,
    input wire logic wordValid
);
    // one clock domain, so clock and disable are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // image copy runs first, so no word may show early
    a_boot_quiet: assert property ($rose(reset_n) |-> (!wordValid &&
        convWord0 == 12'h000 && convWord1 == 12'h000) [*8])
        else $error("word shown before image copy");
    a_valid_sticky: assert property (wordValid |=> wordValid)
        else $error("word valid dropped");
    a_idle_zero: assert property (!wordValid |->
        convWord0 == WORD_RESET && convWord1 == WORD_RESET)
        else $error("word nonzero before first pass");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_write_answer: assert property
        (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    a_bvalid_drop: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer not released");
    a_rvalid_drop: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer not released");
    a_ar_refused: assert property (rvalid |-> !arready)
        else $error("read address taken while answer pending");
    a_unmapped_err: assert property (arvalid && arready &&
        araddr == 12'h030 |=> rresp == RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_upper_width: assert property (arvalid && arready &&
        araddr == OFS_CODE_UPPER |=> rdata[31:4] == 28'h0)
        else $error("upper code register too wide");
endmodule
bind temp_lut_interpolator temp_lut_checker chk_u (.mclk(mclk),
    .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .convWord0(convWord0),
    .convWord1(convWord1), .wordValid(wordValid));
`default_nettype wire

// File: testbench/dac_stage_model.sv
// downstream converter stage model, one latch per channel
`timescale 1ns/1ps
`default_nettype none
module dac_stage_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] convWord0,
    input wire logic [11:0] convWord1,
    input wire logic wordValid,
    output logic [11:0] level0,
    output logic [11:0] level1
);
    // converter ignores the words until they are marked valid
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            level0 <= 12'h000;
            level1 <= 12'h000;
        end else if (wordValid) begin
            level0 <= convWord0;
            level1 <= convWord1;
        end
    end
endmodule
`default_nettype wire

// File: testbench/temp_lut_interpolator_bench.sv
// self-checking bench for the temperature table interpolator
`timescale 1ns/1ps
`default_nettype none
module temp_lut_interpolator_bench;
    import temp_lut_pkg::*;
    localparam int PERIOD = 20; // shortened conversion interval
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] sensorCode = 12'h7FF; // hottest code the sensor gives
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, wordValid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [11:0] convWord0, convWord1, level0, level1, c;
    logic [1:0] rs;
    int numErrors = 0, nCompared = 0;
    int tb[2][64]; // bench copy of both increment tables
    int ofs[2];
    bit inv[2];
    logic [11:0] codes[9] = '{12'h180, 12'h1A5, 12'h3FF, 12'h7FF, 12'h100,
        12'hE40, 12'hE55, 12'h800, 12'hFFF};
    temp_lut_interpolator #(.CONV_PERIOD(PERIOD), .NV_OFFSET0(12'h123),
        .NV_INVERT1(1'b1)) dut_u (.mclk(mclk), .reset_n(reset_n),
        .sensorCode(sensorCode), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .convWord0(convWord0), .convWord1(convWord1),
        .wordValid(wordValid));
    dac_stage_model dac_u (.mclk(mclk), .reset_n(reset_n),
        .convWord0(convWord0), .convWord1(convWord1),
        .wordValid(wordValid), .level0(level0), .level1(level1));
    // free-running 40 MHz clock
    initial forever #12.5 mclk = ~mclk;
    // expected word; fraction truncates, result clamps to 12 bits
    function automatic int expWord(logic [11:0] cd, int ch);
        int loc, r, s, m;
        loc = $signed(cd[11:6]);
        r = cd[5:0];
        s = 0;
        if (loc >= 6) begin
            for (int j = 1; j <= loc - 6; j++) s += tb[ch][j + 12];
            s = s + r * tb[ch][loc + 7] / 64;
        end else begin
            m = (loc < -7) ? 13 : 6 - loc; // no table below the floor
            if (loc < -7) r = 0;
            for (int j = 1; j <= m; j++) s += tb[ch][13 - j];
            // magnitude truncates as a whole, after the part is removed
            s = -((s * 64 - r * tb[ch][13 - m]) / 64);
        end
        s = inv[ch] ? ofs[ch] - s : ofs[ch] + s;
        return (s < 0) ? 0 : ((s > 4095) ? 4095 : s);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // handshakes are sampled mid-cycle, acted on at the next edge
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bit aw, w, got;
        got = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got) begin
            @(negedge mclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            got = bvalid && bready;
            if (got) check(bresp, RESP_OKAY);
            @(posedge mclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (got) bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v,
        output logic [1:0] r);
        bit ar, got;
        got = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(negedge mclk);
            ar = arvalid && arready;
            got = rvalid && rready;
            v = rdata;
            r = rresp;
            @(posedge mclk);
            if (ar) arvalid <= 1'b0;
            if (got) rready <= 1'b0;
        end
    endtask
    task automatic print_verdict();
        $display("counts: %0d compared, %0d mismatched", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge mclk);
        numErrors++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge mclk);
        check({wordValid, convWord0, convWord1}, 0);
        reset_n <= 1'b1;
        rd(OFS_CODE_UPPER, d, rs);
        check(d, 0);
        do rd(OFS_STATUS, d, rs); while (d[0] !== 1'b1);
        rd(OFS_OFFSET0_LOW, d, rs);
        check(d, 32'h23);
        rd(OFS_OFFSET1_HIGH, d, rs);
        check(d, 32'h88);
        $display("test boot done");
        rd(OFS_CODE_UPPER, d, rs);
        check(d, 32'h7);
        rd(OFS_CODE_LOWER, d, rs);
        check(d, 32'hFF);
        sensorCode <= 12'h180;
        repeat (PERIOD + 6) @(posedge mclk);
        rd(OFS_CODE_LOWER, d, rs);
        check(d, 32'h80);
        wr(OFS_CODE_UPPER, 32'hF); // read-only place keeps its value
        rd(OFS_CODE_UPPER, d, rs);
        check(d, 32'h1);
        rd(12'h030, d, rs);
        check(rs, RESP_SLVERR);
        check(d, 32'h0);
        wstrb <= 4'hE; // lane 0 off: the write must not land
        wr(OFS_FORCE_LOWER, 32'h55);
        wstrb <= 4'hF;
        rd(OFS_FORCE_LOWER, d, rs);
        check(d, 32'h0);
        $display("test sensor done");
        wr(12'h104, 32'hFFFF_FFF5);
        rd(12'h104, d, rs);
        check(d, 32'h5);
        for (int ch = 0; ch < 2; ch++) begin
            for (int n = 0; n < 64; n++) begin
                tb[ch][n] = ch ? 15 - (n % 16) : (n * 7) % 16;
                wr({ch ? TABLE1_PAGE : TABLE0_PAGE, n[5:0], 2'b00},
                    tb[ch][n]);
            end
        end
        wr(OFS_MODE, 32'h1);
        inv = '{1'b0, 1'b1};
        // second pass pushes both channels into the clamp
        for (int p = 0; p < 2; p++) begin
            if (p) ofs = '{12'hFF0, 12'h005};
            else ofs = '{12'h800, 12'h400};
            for (int ch = 0; ch < 2; ch++) begin
                c = ofs[ch];
                wr(ch ? OFS_OFFSET1_HIGH : OFS_OFFSET0_HIGH,
                    {inv[ch], 3'b000, c[11:8]});
                wr(ch ? OFS_OFFSET1_LOW : OFS_OFFSET0_LOW, c[7:0]);
            end
            foreach (codes[i]) begin
                c = codes[i];
                wr(OFS_FORCE_UPPER, c[11:8]);
                wr(OFS_FORCE_LOWER, c[7:0]);
                repeat (80) @(posedge mclk);
                check(convWord0, expWord(c, 0));
                check(level1, expWord(c, 1));
                check(level0, expWord(c, 0));
                rd(OFS_WORD1, d, rs);
                check(d, expWord(c, 1));
            end
        end
        $display("test table done");
        wr(OFS_MODE, 32'h0);
        repeat (2 * PERIOD) @(posedge mclk);
        check(convWord0, 12'hFF0);
        $display("test sensor mode done");
        print_verdict();
    end
endmodule
`default_nettype wire
